// ==== src/frr_top.sv ====
`timescale 1ns/1ps
`include "frr_defs.svh"

// Functional notes
// - Retry codes 1 to 6 allow exactly that many restart attempts.
// - When all allowed attempts fail the output stays off until the fault is cleared.
// - Attempts start one delay apart, the delay being two to the power of the delay code times the delay unit.
// - Retry code 7 restarts without limit until commanded off or another fault shuts down.
// - The delay field selects two to the power of its value in delay units, 1 to 128.
// - That delay is either the run-on time after a fault or the retry spacing, in the set unit.
// - A 16-bit writable input over-voltage threshold sits at command 0x55 as a word.
// - Reaction 00 ignores the fault and keeps running.
// - Reaction 01 runs on for the delay, then follows the retry setting if the fault remains.
// - Reaction 10 disables the output at once and then follows the retry setting.
// - Reaction 11 latches off until cleared, reset, or switched off and on again.
// - A writable one-byte input over-voltage reaction register sits at command 0x56.
// - Retry code 0 means no restart; the output stays off until the fault is cleared.
// - The under-temperature reaction byte at command 0x54 shares the same layout.

module frr_top
  import frr_pkg::*;
#(
  parameter int UNIT_CYCLES = `FRR_UNIT_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        ctrl_on,
  input  wire logic        other_shdn,
  input  wire logic [15:0] vin_sample,
  output logic             out_en,
  output logic             vin_ov_flag
);

  function automatic logic [7:0] rd_byte(input logic [7:0] c, input logic hi,
                                         input logic [15:0] lim, input logic [7:0] rsp,
                                         input logic [7:0] ut);
    case (c)
      `FRR_CMD_UTR:   rd_byte = ut;
      `FRR_CMD_VLIM:  rd_byte = hi ? lim[15:8] : lim[7:0];
      `FRR_CMD_VRESP: rd_byte = rsp;
      default:        rd_byte = `FRR_RD_EMPTY;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3, ctl_s1, ctl_s2;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      {scl_s1, scl_s2, scl_s3} <= 3'h7;
      {sda_s1, sda_s2, sda_s3} <= 3'h7;
      {ctl_s1, ctl_s2}         <= 2'h0;
    end else begin
      {scl_s1, scl_s2, scl_s3} <= {scl_in, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_s3} <= {sda_in, sda_s1, sda_s2};
      {ctl_s1, ctl_s2}         <= {ctrl_on, ctl_s1};
    end
  end

  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = scl_s2 & ~scl_s3;
  assign scl_fall = ~scl_s2 & scl_s3;
  assign start_c  = scl_s2 & scl_s3 & ~sda_s2 & sda_s3;
  assign stop_c   = scl_s2 & scl_s3 & sda_s2 & ~sda_s3;

  ////////////////////////////////////////////////////////////////////////////
  // Serial command slave
  frr_phase_t    ph_q, ph_d;
  logic [3:0]    bit_q, bit_d;
  logic [7:0]    sh_q, sh_d, cmd_q, cmd_d, tx_q, tx_d, lo_q, lo_d;
  logic          ack_q, ack_d, wsel_q, wsel_d;
  logic          wr_byte, wr_word, clr_cmd;
  logic [15:0]   vlim_q, vlim_d;
  frr_reaction_t vresp_q, vresp_d, utr_q, utr_d;

  always_comb begin
    ph_d    = ph_q;
    bit_d   = bit_q;
    sh_d    = sh_q;
    cmd_d   = cmd_q;
    tx_d    = tx_q;
    lo_d    = lo_q;
    ack_d   = ack_q;
    wsel_d  = wsel_q;
    wr_byte = 1'b0;
    wr_word = 1'b0;
    clr_cmd = 1'b0;
    if (start_c) begin
      ph_d   = PH_ADDR;
      bit_d  = `FRR_BIT_ACK; // Fall that ends a start carries no bit
      ack_d  = 1'b0;
      wsel_d = 1'b0;
    end else if (stop_c) begin
      ph_d  = PH_IDLE;
      ack_d = 1'b0;
    end else if (ph_q != PH_IDLE) begin
      if (scl_rise) begin
        if (bit_q < `FRR_BIT_ACK) begin
          sh_d = {sh_q[6:0], sda_s2};
        end else if (ph_q == PH_RD && sda_s2) begin
          ph_d = PH_IDLE;
        end
      end else if (scl_fall) begin
        if (bit_q == `FRR_BIT_LAST) begin
          bit_d = `FRR_BIT_ACK;
          case (ph_q)
            PH_ADDR: begin
              if (sh_q[7:1] == `FRR_DEV_ADDR) begin
                ack_d = 1'b1;
                ph_d  = sh_q[0] ? PH_RD : PH_CMD;
                tx_d  = rd_byte(cmd_q, 1'b0, vlim_q, vresp_q, utr_q);
              end else begin
                ph_d = PH_IDLE;
              end
            end
            PH_CMD: begin
              ack_d   = 1'b1;
              cmd_d   = sh_q;
              ph_d    = PH_WR;
              wsel_d  = 1'b0;
              clr_cmd = (sh_q == `FRR_CMD_CLEAR);
            end
            PH_WR: begin
              ack_d = 1'b1;
              if (!wsel_q) begin
                lo_d    = sh_q;
                wsel_d  = 1'b1;
                wr_byte = 1'b1;
              end else begin
                wr_word = 1'b1;
              end
            end
            PH_RD: tx_d = rd_byte(cmd_q, 1'b1, vlim_q, vresp_q, utr_q);
            default: ph_d = PH_IDLE;
          endcase
        end else if (bit_q == `FRR_BIT_ACK) begin
          bit_d = 4'h0;
          ack_d = 1'b0;
        end else begin
          bit_d = bit_q + 4'h1;
        end
      end
    end
  end

  // Combinational drive keeps the reply inside a short low phase of the clock pin
  assign sda_out = 1'b0;
  assign sda_oe  = ack_q | (ph_q == PH_RD && bit_q < `FRR_BIT_ACK && !tx_q[3'h7 - bit_q[2:0]]);

  always_comb begin
    vlim_d  = vlim_q;
    vresp_d = vresp_q;
    utr_d   = utr_q;
    if (wr_word && cmd_q == `FRR_CMD_VLIM) begin
      vlim_d = {sh_q, lo_q};
    end
    if (wr_byte && cmd_q == `FRR_CMD_VRESP) begin
      vresp_d = sh_q;
    end
    if (wr_byte && cmd_q == `FRR_CMD_UTR) begin
      utr_d = sh_q;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ph_q    <= PH_IDLE;
      bit_q   <= 4'h0;
      sh_q    <= 8'h00;
      cmd_q   <= 8'h00;
      tx_q    <= 8'h00;
      lo_q    <= 8'h00;
      ack_q   <= 1'b0;
      wsel_q  <= 1'b0;
      vlim_q  <= `FRR_VLIM_RST;
      vresp_q <= `FRR_RESP_RST;
      utr_q   <= `FRR_UTR_RST;
    end else begin
      ph_q    <= ph_d;
      bit_q   <= bit_d;
      sh_q    <= sh_d;
      cmd_q   <= cmd_d;
      tx_q    <= tx_d;
      lo_q    <= lo_d;
      ack_q   <= ack_d;
      wsel_q  <= wsel_d;
      vlim_q  <= vlim_d;
      vresp_q <= vresp_d;
      utr_q   <= utr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault sequencer
  frr_seq_t   st_q, st_d;
  logic [2:0] tries_q, tries_d;
  logic       flag_q, flag_d, out_q, out_d;
  logic       fault, tmr_start, tmr_done, last_try;
  frr_seq_t   off_target;

  assign fault      = (vin_sample > vlim_q);
  assign off_target = (vresp_q.retry == `FRR_RETRY_NONE) ? SQ_LATCH : SQ_OFFW;
  assign last_try   = (vresp_q.retry != `FRR_RETRY_CONT) &&
                      ({1'b0, tries_q} + 4'h1 >= {1'b0, vresp_q.retry});

  frr_delay_timer #(.UNIT_CYCLES(UNIT_CYCLES)) u_timer (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .start   (tmr_start),
    .code    (vresp_q.delay),
    .done    (tmr_done)
  );

  always_comb begin
    st_d      = st_q;
    tries_d   = tries_q;
    tmr_start = 1'b0;
    flag_d    = (flag_q & ~clr_cmd) | fault;
    if (!ctl_s2) begin
      st_d    = SQ_STOP;
      tries_d = 3'h0;
    end else begin
      case (st_q)
        SQ_STOP: st_d = SQ_RUN;
        SQ_RUN: begin
          if (fault) begin
            case (vresp_q.resp)
              `FRR_RESP_IGNORE: st_d = SQ_RUN;
              `FRR_RESP_HOLD: begin
                st_d      = SQ_HOLD;
                tmr_start = 1'b1;
              end
              `FRR_RESP_SHUT: begin
                st_d      = off_target;
                tmr_start = 1'b1;
                tries_d   = 3'h0;
              end
              default: st_d = SQ_LATCH;
            endcase
          end
        end
        SQ_HOLD: begin
          if (tmr_done) begin
            st_d      = fault ? off_target : SQ_RUN;
            tmr_start = fault;
            tries_d   = 3'h0;
          end
        end
        SQ_OFFW: begin
          if (other_shdn) begin
            st_d = SQ_LATCH;
          end else if (tmr_done) begin
            if (!fault) begin
              st_d    = SQ_RUN;
              tries_d = 3'h0;
            end else if (last_try) begin
              st_d = SQ_LATCH;
            end else begin
              tries_d   = tries_q + 3'h1;
              tmr_start = 1'b1;
            end
          end
        end
        SQ_LATCH: begin
          if (clr_cmd) begin
            st_d    = SQ_RUN;
            tries_d = 3'h0;
          end
        end
        default: st_d = SQ_STOP;
      endcase
    end
    out_d = (st_d == SQ_RUN) || (st_d == SQ_HOLD);
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_q    <= SQ_STOP;
      tries_q <= 3'h0;
      flag_q  <= 1'b0;
      out_q   <= 1'b0;
    end else begin
      st_q    <= st_d;
      tries_q <= tries_d;
      flag_q  <= flag_d;
      out_q   <= out_d;
    end
  end

  assign out_en      = out_q;
  assign vin_ov_flag = flag_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_ignore;
    @(posedge sys_clk) disable iff (!nrst)
      st_q == SQ_RUN && ctl_s2 && fault && vresp_q.resp == `FRR_RESP_IGNORE |=> out_en;
  endproperty
  a_ignore: assert property (p_ignore) else $error("Ignored fault dropped the output");

  property p_shut;
    @(posedge sys_clk) disable iff (!nrst)
      st_q == SQ_RUN && ctl_s2 && fault && vresp_q.resp == `FRR_RESP_SHUT |=> !out_en;
  endproperty
  a_shut: assert property (p_shut) else $error("Shutdown reaction kept the output on");

  property p_latch;
    @(posedge sys_clk) disable iff (!nrst)
      st_q == SQ_RUN && ctl_s2 && fault && vresp_q.resp == `FRR_RESP_LATCH |=> st_q == SQ_LATCH ##1 !out_en;
  endproperty
  a_latch: assert property (p_latch) else $error("Latch reaction did not latch off");

  property p_noretry;
    @(posedge sys_clk) disable iff (!nrst)
      st_q == SQ_RUN && ctl_s2 && fault && vresp_q.resp == `FRR_RESP_SHUT &&
      vresp_q.retry == `FRR_RETRY_NONE |=> st_q == SQ_LATCH;
  endproperty
  a_noretry: assert property (p_noretry) else $error("Zero retry setting still retried");

  property p_giveup;
    @(posedge sys_clk) disable iff (!nrst)
      st_q == SQ_OFFW && ctl_s2 && !other_shdn && tmr_done && fault && vresp_q.retry != `FRR_RETRY_CONT &&
      tries_q + 3'h1 == vresp_q.retry |=> st_q == SQ_LATCH ##1 !out_en;
  endproperty
  a_giveup: assert property (p_giveup) else $error("Output not held off after last attempt");

  property p_endless;
    @(posedge sys_clk) disable iff (!nrst)
      st_q == SQ_OFFW && ctl_s2 && !other_shdn && tmr_done && fault &&
      vresp_q.retry == `FRR_RETRY_CONT |=> st_q == SQ_OFFW;
  endproperty
  a_endless: assert property (p_endless) else $error("Continuous retry stopped");

  property p_holdon;
    @(posedge sys_clk) disable iff (!nrst)
      st_q == SQ_HOLD && ctl_s2 && !tmr_done |=> out_en;
  endproperty
  a_holdon: assert property (p_holdon) else $error("Output dropped during run-on delay");

  property p_limit;
    @(posedge sys_clk) disable iff (!nrst)
      wr_word && cmd_q == `FRR_CMD_VLIM |=> vlim_q == {$past(sh_q), $past(lo_q)};
  endproperty
  a_limit: assert property (p_limit) else $error("Threshold word not stored");

  property p_flag;
    @(posedge sys_clk) disable iff (!nrst)
      fault |=> vin_ov_flag;
  endproperty
  a_flag: assert property (p_flag) else $error("Over-voltage flag missed");

endmodule

// ==== src/frr_defs.svh ====
`ifndef FRR_DEFS_SVH
`define FRR_DEFS_SVH

// Command codes
`define FRR_CMD_CLEAR  8'h03
`define FRR_CMD_UTR    8'h54
`define FRR_CMD_VLIM   8'h55
`define FRR_CMD_VRESP  8'h56
`define FRR_DEV_ADDR   7'h40

// Reset values
`define FRR_VLIM_RST   16'hffff
`define FRR_RESP_RST   8'h80
`define FRR_UTR_RST    8'h80
`define FRR_RD_EMPTY   8'hff

// Reaction codes
`define FRR_RESP_IGNORE 2'h0
`define FRR_RESP_HOLD   2'h1
`define FRR_RESP_SHUT   2'h2
`define FRR_RESP_LATCH  2'h3
`define FRR_RETRY_NONE  3'h0
`define FRR_RETRY_CONT  3'h7

// Serial bit positions
`define FRR_BIT_LAST   4'h7
`define FRR_BIT_ACK    4'h8

// Delay unit timing
`define FRR_UNIT_NS    1000
`define FRR_CLK_NS     10
`define FRR_UNIT_CYC   ((`FRR_UNIT_NS + `FRR_CLK_NS - 1) / `FRR_CLK_NS)

`endif

// ==== src/frr_pkg.sv ====
package frr_pkg;

  typedef struct packed {
    logic [1:0] resp;
    logic [2:0] retry;
    logic [2:0] delay;
  } frr_reaction_t;

  typedef enum logic [2:0] {SQ_STOP, SQ_RUN, SQ_HOLD, SQ_OFFW, SQ_LATCH} frr_seq_t;

  typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_CMD, PH_WR, PH_RD} frr_phase_t;

endpackage

// ==== src/frr_delay_timer.sv ====
`timescale 1ns/1ps
`include "frr_defs.svh"

module frr_delay_timer
  import frr_pkg::*;
#(
  parameter int UNIT_CYCLES = `FRR_UNIT_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic       start,
  input  wire logic [2:0] code,
  output logic            done
);

  function automatic logic [7:0] units_of(input logic [2:0] c);
    units_of = 8'h01 << c;
  endfunction

  logic        busy_q, busy_d;
  logic [15:0] unit_q, unit_d;
  logic [7:0]  cnt_q,  cnt_d;
  logic [2:0]  code_q, code_d;
  logic        unit_end;

  assign unit_end = (unit_q == 16'(UNIT_CYCLES - 1));
  assign done     = busy_q && unit_end && (cnt_q == units_of(code_q) - 8'h01);

  always_comb begin
    busy_d = busy_q;
    unit_d = unit_q;
    cnt_d  = cnt_q;
    code_d = code_q;
    if (start) begin
      busy_d = 1'b1;
      unit_d = 16'h0000;
      cnt_d  = 8'h00;
      code_d = code;
    end else if (busy_q) begin
      unit_d = unit_end ? 16'h0000 : unit_q + 16'h0001;
      if (unit_end) begin
        cnt_d = cnt_q + 8'h01;
        if (done) begin
          busy_d = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      busy_q <= 1'b0;
      unit_q <= 16'h0000;
      cnt_q  <= 8'h00;
      code_q <= 3'h0;
    end else begin
      busy_q <= busy_d;
      unit_q <= unit_d;
      cnt_q  <= cnt_d;
      code_q <= code_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helper count, read only by the check
  int elapsed_q;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      elapsed_q <= 0;
    end else begin
      elapsed_q <= start ? 1 : elapsed_q + 1;
    end
  end

  property p_span;
    @(posedge sys_clk) disable iff (!nrst)
      done |-> elapsed_q == int'(units_of(code_q)) * UNIT_CYCLES;
  endproperty
  a_span: assert property (p_span) else $error("Delay span differs from two to the code times unit");

endmodule

// ==== tb/frr_host.sv ====
`timescale 1ns/1ps
`include "frr_defs.svh"

// Bus host: SCL period 8 system cycles, 5 low and 3 high; SCL idles high
module frr_host (
  input  wire logic sys_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  ////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Data moves a cycle after SCL falls, clear of the device's own release
  task automatic bit_io(input logic b, output logic r);
    tick(1);
    sda_pull <= ~b;
    tick(4);
    scl <= 1'b1;
    tick(2);
    @(negedge sys_clk);
    r = sda;
    tick(1);
    scl <= 1'b0;
  endtask

  // Longer low phase so a pending acknowledge is gone before SCL rises
  task automatic start_cond();
    tick(1);
    sda_pull <= 1'b0;
    tick(6);
    scl <= 1'b1;
    tick(4);
    sda_pull <= 1'b1;
    tick(4);
    scl <= 1'b0;
  endtask

  task automatic stop_cond();
    tick(1);
    sda_pull <= 1'b1;
    tick(4);
    scl <= 1'b1;
    tick(4);
    sda_pull <= 1'b0;
    tick(8);
  endtask

  ////////////////////////////////////////
  task automatic byte_tx(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  task automatic byte_rx(input logic nack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(nack, r);
  endtask

  // Words go low byte first
  task automatic wr(input logic [7:0] cmd, input logic [15:0] d, input int n, output logic ok);
    logic a0, a1, a2, a3;
    a2 = 1'b1;
    a3 = 1'b1;
    start_cond();
    byte_tx({`FRR_DEV_ADDR, 1'b0}, a0);
    byte_tx(cmd, a1);
    if (n > 0) begin
      byte_tx(d[7:0], a2);
    end
    if (n > 1) begin
      byte_tx(d[15:8], a3);
    end
    stop_cond();
    ok = a0 & a1 & a2 & a3;
  endtask

  task automatic rd(input logic [7:0] cmd, input int n, output logic [15:0] d, output logic ok);
    logic       a0, a1, a2;
    logic [7:0] lo, hi;
    hi = 8'h00;
    start_cond();
    byte_tx({`FRR_DEV_ADDR, 1'b0}, a0);
    byte_tx(cmd, a1);
    start_cond();
    byte_tx({`FRR_DEV_ADDR, 1'b1}, a2);
    byte_rx(n == 1, lo);
    if (n > 1) begin
      byte_rx(1'b1, hi);
    end
    stop_cond();
    d = {hi, lo};
    ok = a0 & a1 & a2;
  endtask
endmodule

// ==== tb/test_fault_response_retry_logic.sv ====
`timescale 1ns/1ps
`include "frr_defs.svh"

`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin bad_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end

module test_fault_response_retry_logic import frr_pkg::*; ;
  localparam int          UNIT  = 4;
  localparam logic [15:0] THR   = 16'h1000;
  localparam logic [15:0] SAFE  = 16'h0800;
  localparam logic [15:0] FAULT = 16'h2000;

  // Fault length m counts whole delays that pass before the fault goes away
  typedef struct packed {
    frr_reaction_t rsp;
    logic [3:0]    m;
    logic          on;
    logic          drop;
  } frr_row_t;

  logic        sys_clk;
  logic        nrst;
  logic        scl;
  logic        host_pull;
  logic        sda_out;
  logic        sda_oe;
  logic        ctrl_on;
  logic        other_shdn;
  logic [15:0] vin_sample;
  logic        out_en;
  logic        vin_ov_flag;
  wire         sda_line;
  int          bad_count;
  int          n_tests;
  int          cyc;
  logic        ok;
  logic [15:0] rdat;
  frr_row_t    r;
  int          d;
  int          drop_at;
  int          on_at;

  frr_row_t rows [23] = '{'{8'h00, 4'd3, 1'b1, 1'b0}, '{8'h42, 4'd0, 1'b1, 1'b0}, '{8'h4a, 4'd1, 1'b1, 1'b1},
    '{8'h4a, 4'd2, 1'b0, 1'b1}, '{8'h82, 4'd0, 1'b0, 1'b1}, '{8'h8a, 4'd0, 1'b1, 1'b1},
    '{8'h8a, 4'd1, 1'b0, 1'b1}, '{8'h92, 4'd1, 1'b1, 1'b1}, '{8'h9a, 4'd2, 1'b1, 1'b1},
    '{8'h9a, 4'd3, 1'b0, 1'b1}, '{8'ha2, 4'd4, 1'b0, 1'b1}, '{8'haa, 4'd4, 1'b1, 1'b1},
    '{8'hb2, 4'd5, 1'b1, 1'b1}, '{8'hb2, 4'd6, 1'b0, 1'b1}, '{8'hba, 4'd8, 1'b1, 1'b1},
    '{8'hc2, 4'd0, 1'b0, 1'b1}, '{8'h88, 4'd0, 1'b1, 1'b1}, '{8'h89, 4'd0, 1'b1, 1'b1},
    '{8'h8b, 4'd0, 1'b1, 1'b1}, '{8'h8c, 4'd0, 1'b1, 1'b1}, '{8'h8d, 4'd0, 1'b1, 1'b1},
    '{8'h8e, 4'd0, 1'b1, 1'b1}, '{8'h8f, 4'd0, 1'b1, 1'b1}};

  // Open-drain data line with pull-up
  assign sda_line = ((sda_oe && !sda_out) || host_pull) ? 1'b0 : 1'b1;

  frr_top #(.UNIT_CYCLES(UNIT)) i_dut (.sys_clk(sys_clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .ctrl_on(ctrl_on), .other_shdn(other_shdn), .vin_sample(vin_sample),
    .out_en(out_en), .vin_ov_flag(vin_ov_flag));

  frr_host i_host (.sys_clk(sys_clk), .sda(sda_line), .scl(scl), .sda_pull(host_pull));

  ////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Whole run is near 26000 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic clear_faults();
    i_host.wr(`FRR_CMD_CLEAR, 16'h0000, 0, ok);
    wait_cyc(4);
    `CHK({ok, out_en, vin_ov_flag}, 3'b110)
  endtask

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    ctrl_on = 1'b1;
    other_shdn = 1'b0;
    vin_sample = SAFE;
    wait_cyc(3);
    nrst <= 1'b1;
    wait_cyc(10);
    `CHK({out_en, vin_ov_flag}, 2'b10)
    i_host.rd(`FRR_CMD_VLIM, 2, rdat, ok);
    `CHK({ok, rdat}, {1'b1, `FRR_VLIM_RST})
    i_host.rd(`FRR_CMD_VRESP, 1, rdat, ok);
    `CHK({ok, rdat}, {9'h100, `FRR_RESP_RST})
    i_host.rd(`FRR_CMD_UTR, 1, rdat, ok);
    `CHK({ok, rdat}, {9'h100, `FRR_UTR_RST})
    i_host.wr(`FRR_CMD_UTR, 16'h005a, 1, ok);
    i_host.rd(`FRR_CMD_UTR, 1, rdat, ok);
    `CHK({ok, rdat}, 17'h1005a)
    // A lone byte to the word register is dropped
    i_host.wr(`FRR_CMD_VLIM, THR, 2, ok);
    i_host.wr(`FRR_CMD_VLIM, 16'h0033, 1, ok);
    i_host.rd(`FRR_CMD_VLIM, 2, rdat, ok);
    `CHK({ok, rdat}, {1'b1, THR})
    i_host.rd(8'h20, 1, rdat, ok);
    `CHK({ok, rdat[7:0]}, {1'b1, `FRR_RD_EMPTY})
    i_host.start_cond();
    i_host.byte_tx(8'h44, ok);
    i_host.stop_cond();
    `CHK(ok, 1'b0)
    // Equal to the limit is not above it
    vin_sample <= THR;
    wait_cyc(20);
    `CHK(vin_ov_flag, 1'b0)
    vin_sample <= SAFE;
    foreach (rows[i]) begin
      r = rows[i];
      d = UNIT << r.rsp.delay;
      i_host.wr(`FRR_CMD_VRESP, {8'h00, r.rsp}, 1, ok);
      i_host.rd(`FRR_CMD_VRESP, 1, rdat, ok);
      `CHK({ok, rdat[7:0]}, {1'b1, r.rsp})
      drop_at = -1;
      on_at = -1;
      vin_sample <= FAULT;
      for (int c = 0; c < (r.m + 2) * d + 40; c++) begin
        @(posedge sys_clk);
        if (c == r.m * d + d / 2) begin
          vin_sample <= SAFE;
        end
        @(negedge sys_clk);
        if (out_en !== 1'b1 && drop_at < 0) begin
          drop_at = c;
        end
        if (out_en === 1'b1 && drop_at >= 0 && on_at < 0) begin
          on_at = c;
        end
      end
      `CHK({out_en, drop_at >= 0, vin_ov_flag}, {r.on, r.drop, 1'b1})
      if (r.rsp.resp == `FRR_RESP_HOLD && r.drop) begin
        `CHK(drop_at, d)
      end
      if (r.rsp.resp[1]) begin
        `CHK(drop_at, 0)
      end
      if (r.rsp.resp == `FRR_RESP_SHUT && r.on) begin
        `CHK(on_at >= (r.m + 1) * d && on_at <= (r.m + 1) * d + 4, 1'b1)
      end
      clear_faults();
    end
    // Commanded off stops continuous retry
    i_host.wr(`FRR_CMD_VRESP, 16'h00ba, 1, ok);
    vin_sample <= FAULT;
    wait_cyc(40);
    ctrl_on <= 1'b0;
    wait_cyc(10);
    vin_sample <= SAFE;
    wait_cyc(60);
    `CHK(out_en, 1'b0)
    ctrl_on <= 1'b1;
    wait_cyc(10);
    `CHK(out_en, 1'b1)
    clear_faults();
    // Another shutdown during the wait also stops it
    vin_sample <= FAULT;
    wait_cyc(40);
    other_shdn <= 1'b1;
    vin_sample <= SAFE;
    wait_cyc(1);
    other_shdn <= 1'b0;
    wait_cyc(60);
    `CHK(out_en, 1'b0)
    clear_faults();
    // Latched off, released by switching off and on
    i_host.wr(`FRR_CMD_VRESP, 16'h00c2, 1, ok);
    vin_sample <= FAULT;
    wait_cyc(8);
    vin_sample <= SAFE;
    wait_cyc(50);
    `CHK(out_en, 1'b0)
    ctrl_on <= 1'b0;
    wait_cyc(10);
    ctrl_on <= 1'b1;
    wait_cyc(10);
    `CHK(out_en, 1'b1)
    clear_faults();
    // Second reset in mid-run, taken while latched off
    vin_sample <= FAULT;
    wait_cyc(8);
    vin_sample <= SAFE;
    wait_cyc(2);
    `CHK(out_en, 1'b0)
    nrst <= 1'b0;
    wait_cyc(3);
    `CHK({out_en, vin_ov_flag, sda_oe}, 3'b000)
    nrst <= 1'b1;
    wait_cyc(10);
    i_host.rd(`FRR_CMD_VLIM, 2, rdat, ok);
    `CHK({ok, out_en, rdat}, {2'b11, `FRR_VLIM_RST})
    tally_and_finish();
  end
endmodule
